/* File: rtl/mcl_pkg.sv */
// Shared constants and carriers for the modem control and status lamp block.
// Assumes a single 10 MHz clock and an active-low asynchronous reset.
package mcl_pkg;
   // Core clock rate in kHz, used to derive the millisecond divider.
   localparam int CLK_KHZ = 10000;
   // Lamp pattern times in milliseconds.
   localparam logic [11:0] REG_ON_MS = 12'h258;   // 600 ms.
   localparam logic [11:0] REG_OFF_MS = 12'h258;  // 600 ms.
   localparam logic [11:0] CTX_FLASH_MS = 12'h04b; // 75 ms.
   localparam logic [11:0] CTX_GAP_MS = 12'hbb8;  // 3 s.
   localparam logic [11:0] XFER_FLASH_MS = 12'h1f4; // 0.5 s.
   // Phase indices of the context double flash.
   localparam logic [1:0] PH_FIRST = 2'h0;
   localparam logic [1:0] PH_LAST = 2'h3;
   // Terminal-ready behaviour codes.
   localparam logic [1:0] DTRB_IGNORE = 2'h0;
   localparam logic [1:0] DTRB_CMD = 2'h1;
   localparam logic [1:0] DTRB_HANGUP = 2'h2;
   localparam logic [1:0] DTRB_RESET = 2'h3;
   // Async mode in which terminal-ready off causes no reaction; o_keep_connection still follows the line.
   localparam logic [2:0] ASYNC_DIRECT = 3'h0;
   // Factory default configuration.
   localparam logic [1:0] DFLT_DTRB = 2'h2;
   localparam logic [2:0] DFLT_ASYNC = 3'h5;

   // Configuration selected by the two configuration commands.
   typedef struct packed {
      logic [1:0] terminal_ready_behaviour_cmd; // Reaction to terminal-ready off.
      logic [2:0] async_mode_select_cmd;        // Async operating mode.
   } mcl_cfg_t;

   // Engine status flags that choose the lamp pattern.
   typedef struct packed {
      logic engine_on;  // Low while off, asleep or in alarm mode.
      logic call_on;    // Voice or data call connected or negotiating.
      logic pkt_event;  // One-cycle pulse per packet exchange.
      logic ctx_active; // One or more packet-data contexts active.
      logic reg_busy;   // No SIM, no PIN, search, authentication or login.
   } mcl_status_t;

   // Lamp pattern states, Gray coded along off, register, context, transfer, call.
   typedef enum logic [2:0] {
      MCL_LAMP_OFF = 3'h0,
      MCL_LAMP_REG = 3'h1,
      MCL_LAMP_CTX = 3'h3,
      MCL_LAMP_XFER = 3'h2,
      MCL_LAMP_CALL = 3'h6
   } mcl_lamp_t;
endpackage : mcl_pkg

/* File: rtl/mcl_modem_ctrl.sv */
// Modem control lines, reset settling and link status lamp patterns.
// Assumes host pins are asynchronous; engine-side signals share i_clk.
`timescale 1ns/10ps
`default_nettype none
module mcl_modem_ctrl #(
   parameter int CLK_PER_MS = mcl_pkg::CLK_KHZ, // Clock cycles per millisecond tick.
   parameter int SETTLE_MS = 100                // Settling interval after reset.
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_nrst,
   // Host pins, the control lines active low, all asynchronous to i_clk.
   input wire logic i_rts_n,
   input wire logic i_dtr_n,
   input wire logic i_txd,
   // Engine-side configuration and status.
   input wire logic i_nv_valid,
   input wire mcl_pkg::mcl_cfg_t i_nv_cfg,
   input wire logic i_cfg_wr,
   input wire mcl_pkg::mcl_cfg_t i_cfg_data,
   input wire mcl_pkg::mcl_status_t i_status,
   input wire logic i_tx_space,
   input wire logic i_ring_on,
   input wire logic i_answer_req,
   input wire logic i_data_connected,
   // Host pins driven by the module, active low.
   output logic o_cts_n,
   output logic o_dsr_n,
   output logic o_ri_n,
   output logic o_dcd_n,
   output logic o_link_status_lamp_n,
   // Engine-side results.
   output logic o_cmd_ready,
   output logic o_txd,
   output logic o_rx_deliver_ok,
   output logic o_offhook,
   output logic o_keep_connection,
   output logic o_to_cmd_mode,
   output logic o_hangup,
   output logic o_cfg_reload,
   output mcl_pkg::mcl_cfg_t o_cfg
);
   // Two-stage synchronisers for the host pins; stage one feeds stage two only.
   // Nothing but stage two may read stage one, or a metastable level could leak into logic.
   // The cost is three cycles of latency from a pin to any output that it steers.
   // At 10 MHz that is far below any character time on the serial line.
   logic [2:0] sync1;
   logic [2:0] sync2;
   logic dtr_off_prev; // Previous terminal-ready level for edge detection.

   // Reset settling and configuration state.
   logic cfg_loaded; // First clock after release has loaded the configuration.
   logic ready;      // Settling interval over.
   logic [15:0] settle_cnt;
   logic [15:0] div_cnt;
   logic ms_tick;

   // Lamp pattern state.
   mcl_pkg::mcl_lamp_t lamp_mode;
   mcl_pkg::mcl_lamp_t next_lamp_mode;
   logic [1:0] phase;
   logic [11:0] ms_cnt;
   logic [11:0] xfer_cnt; // Remaining transfer flash time.
   logic lamp_on;

   // Synchronised host levels.
   wire rts_n_s = sync2[0];
   wire dtr_n_s = sync2[1];
   wire txd_s = sync2[2];

   // Phase length in milliseconds for a pattern and phase.
   function automatic logic [11:0] phase_len(input mcl_pkg::mcl_lamp_t m, input logic [1:0] p);
      logic [11:0] len;
      len = mcl_pkg::XFER_FLASH_MS;
      case (m)
         mcl_pkg::MCL_LAMP_REG: len = p[0] ? mcl_pkg::REG_OFF_MS : mcl_pkg::REG_ON_MS;
         mcl_pkg::MCL_LAMP_CTX: len = (p == mcl_pkg::PH_LAST) ? mcl_pkg::CTX_GAP_MS : mcl_pkg::CTX_FLASH_MS;
         default: len = mcl_pkg::XFER_FLASH_MS;
      endcase
      return len;
   endfunction : phase_len

   // Host pins are sampled through two flops to avoid metastability.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         sync1 <= 3'h7;
         sync2 <= 3'h7;
         dtr_off_prev <= 1'b1;
      end else begin
         sync1 <= {i_txd, i_dtr_n, i_rts_n};
         sync2 <= sync1;
         dtr_off_prev <= dtr_n_s;
      end
   end

   // Millisecond tick divider; all lamp timing derives from it.
   // The divider runs free and is never restarted by a pattern change.
   // A first phase may therefore be short by up to one millisecond.
   // That error is invisible on a lamp and saves a second counter per pattern.
   assign ms_tick = (div_cnt == 16'(CLK_PER_MS - 1));
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         div_cnt <= 16'h0000;
      end else if (ms_tick) begin
         div_cnt <= 16'h0000;
      end else begin
         div_cnt <= div_cnt + 16'h0001;
      end
   end

   // Settling counter; commands are refused until it runs out.
   // The counter stops once ready is set, so ready never drops again without a reset.
   // Its width limits the settling interval to 65536 milliseconds.
   // A longer interval needs a wider counter, not a slower tick.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         settle_cnt <= 16'h0000;
         ready <= 1'b0;
      end else if (!ready && ms_tick) begin
         if (settle_cnt == 16'(SETTLE_MS - 1)) begin
            ready <= 1'b1;
         end else begin
            settle_cnt <= settle_cnt + 16'h0001;
         end
      end
   end
   assign o_cmd_ready = ready;

   // Terminal-ready off edge and the configured reaction to it.
   // Only the rising edge of the synchronised line acts, so a host that holds the
   // line high for a long time causes one reaction, not one per cycle.
   // Edges before ready are ignored, because the configuration may not be settled yet.
   // In the direct async mode the off edge causes no reaction, whatever the behaviour code; o_keep_connection still follows the line.
   wire dtr_off_edge = dtr_n_s && !dtr_off_prev && ready;
   wire dtr_watched = (o_cfg.async_mode_select_cmd != mcl_pkg::ASYNC_DIRECT);
   wire dtr_act = dtr_off_edge && dtr_watched;
   wire [1:0] dtr_beh = o_cfg.terminal_ready_behaviour_cmd;
   wire do_cmd = dtr_act && (dtr_beh == mcl_pkg::DTRB_CMD);
   wire do_hang = dtr_act && ((dtr_beh == mcl_pkg::DTRB_HANGUP) || (dtr_beh == mcl_pkg::DTRB_RESET));
   wire do_reload = dtr_act && (dtr_beh == mcl_pkg::DTRB_RESET);

   // Stored value wins over factory default; a reset reaction reloads it too.
   wire mcl_pkg::mcl_cfg_t boot_cfg = i_nv_valid ? i_nv_cfg :
      mcl_pkg::mcl_cfg_t'({mcl_pkg::DFLT_DTRB, mcl_pkg::DFLT_ASYNC});

   // Configuration register: the strap-like image is caught after release.
   // The reset branch may hold only constants, so the stored image is taken on the
   // first edge after release instead of inside reset.
   // Until then the factory defaults stand, which is a safe value for one cycle.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cfg_loaded <= 1'b0;
         o_cfg <= mcl_pkg::mcl_cfg_t'({mcl_pkg::DFLT_DTRB, mcl_pkg::DFLT_ASYNC});
      end else if (!cfg_loaded || do_reload) begin
         cfg_loaded <= 1'b1;
         o_cfg <= boot_cfg;
      end else if (i_cfg_wr && ready) begin
         o_cfg <= i_cfg_data;
      end
   end

   // Disconnect reactions are one-cycle pulses to the engine.
   // The engine must catch them on the edge at which they stand; they are not held.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_to_cmd_mode <= 1'b0;
         o_hangup <= 1'b0;
         o_cfg_reload <= 1'b0;
      end else begin
         o_to_cmd_mode <= do_cmd;
         o_hangup <= do_hang;
         o_cfg_reload <= do_reload;
      end
   end

   // Modem control outputs, all registered.
   // Ready gates every control line so nothing is promised before settling ends; the o_txd pass-through is not gated.
   // Ring indicate is the exception: the host watches it even while data-set-ready
   // is off, so it follows the ring cadence at all times.
   // Off-hook waits for the ring on-segment to end, so it never overlaps ring indicate.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_cts_n <= 1'b1;
         o_dsr_n <= 1'b1;
         o_ri_n <= 1'b1;
         o_dcd_n <= 1'b1;
         o_txd <= 1'b1;
         o_rx_deliver_ok <= 1'b0;
         o_offhook <= 1'b0;
         o_keep_connection <= 1'b0;
      end else begin
         o_cts_n <= !(ready && i_tx_space);
         o_txd <= txd_s;
         o_dsr_n <= !ready;
         o_ri_n <= !i_ring_on;
         o_dcd_n <= !(ready && i_data_connected);
         o_rx_deliver_ok <= ready && !rts_n_s;
         o_offhook <= ready && i_answer_req && !i_ring_on;
         o_keep_connection <= ready && !dtr_n_s;
      end
   end

   // Transfer flash: each packet exchange starts a fresh 0.5 s flash at once.
   // A packet pulse in the same cycle as a countdown step wins, so a steady stream
   // of packets keeps the lamp lit without a gap.
   // The lamp lights on the second edge after a packet, well inside one second.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         xfer_cnt <= 12'h000;
      end else if (i_status.pkt_event) begin
         xfer_cnt <= mcl_pkg::XFER_FLASH_MS;
      end else if (ms_tick && (xfer_cnt != 12'h000)) begin
         xfer_cnt <= xfer_cnt - 12'h001;
      end
   end

   // Pattern selection by fixed priority.
   // An engine that is off, asleep or in alarm mode overrides every other status.
   // The packet pulse itself selects the transfer pattern, so the flash starts on the
   // same edge that loads the countdown.
   always_comb begin
      if (!i_status.engine_on) begin
         next_lamp_mode = mcl_pkg::MCL_LAMP_OFF;
      end else if (i_status.call_on) begin
         next_lamp_mode = mcl_pkg::MCL_LAMP_CALL;
      end else if (i_status.pkt_event || (xfer_cnt != 12'h000)) begin
         next_lamp_mode = mcl_pkg::MCL_LAMP_XFER;
      end else if (i_status.ctx_active) begin
         next_lamp_mode = mcl_pkg::MCL_LAMP_CTX;
      end else if (i_status.reg_busy) begin
         next_lamp_mode = mcl_pkg::MCL_LAMP_REG;
      end else begin
         next_lamp_mode = mcl_pkg::MCL_LAMP_OFF;
      end
   end

   // Phase sequencer; a change of pattern restarts at the first phase.
   // A phase ends on the tick at which its millisecond count reaches its length,
   // so every phase but a first one lasts exactly its nominal time.
   // The registration blink wraps after two phases and the double flash after four.
   wire mode_change = (next_lamp_mode != lamp_mode);
   wire phase_end = ms_tick && (ms_cnt >= phase_len(lamp_mode, phase) - 12'h001);
   wire [1:0] wrap_phase = (lamp_mode == mcl_pkg::MCL_LAMP_REG) ? 2'h1 : mcl_pkg::PH_LAST;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         lamp_mode <= mcl_pkg::MCL_LAMP_OFF;
         phase <= mcl_pkg::PH_FIRST;
         ms_cnt <= 12'h000;
      end else if (mode_change) begin
         lamp_mode <= next_lamp_mode;
         phase <= mcl_pkg::PH_FIRST;
         ms_cnt <= 12'h000;
      end else if (phase_end) begin
         ms_cnt <= 12'h000;
         phase <= (phase == wrap_phase) ? mcl_pkg::PH_FIRST : phase + 2'h1;
      end else if (ms_tick) begin
         ms_cnt <= ms_cnt + 12'h001;
      end
   end

   // Lit phases: even phases blink on; the fourth context phase is the gap.
   // Transfer and call patterns ignore the phase and show a steady lamp.
   always_comb begin
      case (lamp_mode)
         mcl_pkg::MCL_LAMP_REG: lamp_on = !phase[0];
         mcl_pkg::MCL_LAMP_CTX: lamp_on = !phase[0];
         mcl_pkg::MCL_LAMP_XFER: lamp_on = 1'b1;
         mcl_pkg::MCL_LAMP_CALL: lamp_on = 1'b1;
         default: lamp_on = 1'b0;
      endcase
   end

   // The lamp pin sinks current to light, so it is registered inverted.
   // Registering it keeps decode glitches off the pin; the cost is one cycle of delay.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_link_status_lamp_n <= 1'b1;
      end else begin
         o_link_status_lamp_n <= !lamp_on;
      end
   end
endmodule : mcl_modem_ctrl
`default_nettype wire

/* File: verif/mcl_modem_ctrl_assertions.sv */
// Checker for the modem control and lamp block, bound to its top ports.
// Assumes one clock domain, reset active low, ready after SETTLE_MS ms.
`timescale 1ns/10ps
`default_nettype none
module mcl_modem_ctrl_assertions #(
   parameter int CLK_PER_MS = 10, // Clock cycles per millisecond tick.
   parameter int SETTLE_MS = 2    // Settling interval in ms.
) (
   // Clock, reset and causes.
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_rts_n,
   input wire logic i_txd,
   input wire mcl_pkg::mcl_status_t i_status,
   input wire logic i_tx_space,
   input wire logic i_ring_on,
   input wire logic i_data_connected,
   // Results that are watched.
   input wire logic o_cts_n,
   input wire logic o_dsr_n,
   input wire logic o_ri_n,
   input wire logic o_dcd_n,
   input wire logic o_link_status_lamp_n,
   input wire logic o_cmd_ready,
   input wire logic o_txd,
   input wire logic o_rx_deliver_ok,
   input wire logic o_offhook,
   input wire logic o_hangup,
   input wire logic o_cfg_reload
);
   // Cycles since reset release; it saturates so a long run never wraps.
   int unsigned age;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst)
         age <= 0;
      else if (age < 100000)
         age <= age + 1;
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   settle_early_a: assert property (age < (SETTLE_MS - 1) * CLK_PER_MS |-> !o_cmd_ready) else $error("ready early");
   settle_late_a: assert property (age > (SETTLE_MS + 1) * CLK_PER_MS |-> o_cmd_ready) else $error("ready late");
   dsr_local_a: assert property (o_cmd_ready |=> !o_dsr_n) else $error("dsr not on");
   cts_space_a: assert property (o_cmd_ready |=> o_cts_n == !$past(i_tx_space)) else $error("cts wrong");
   ring_hold_a: assert property (i_ring_on |=> !o_ri_n && !o_offhook) else $error("ring wrong");
   dcd_conn_a: assert property (o_cmd_ready |=> o_dcd_n == !$past(i_data_connected)) else $error("dcd wrong");
   rx_gate_a: assert property ((o_cmd_ready && $stable(i_rts_n))[*4] |-> o_rx_deliver_ok == !i_rts_n)
      else $error("deliver wrong");
   tx_pass_a: assert property (o_cmd_ready |-> o_txd == $past(i_txd, 3)) else $error("txd wrong");
   reload_pulse_a: assert property (o_cfg_reload |-> o_hangup ##1 !o_hangup) else $error("reload wrong");
   lamp_dark_a: assert property ((!i_status.engine_on)[*3] |-> o_link_status_lamp_n) else $error("lamp lit");
   call_steady_a: assert property ((i_status.engine_on && i_status.call_on)[*3] |-> !o_link_status_lamp_n)
      else $error("lamp dark in call");
   // Main scenarios that the bench is expected to reach.
   ring_seen_c: cover property (!o_ri_n);
   lamp_lit_c: cover property ($fell(o_link_status_lamp_n));
   reload_seen_c: cover property (o_cfg_reload);
endmodule : mcl_modem_ctrl_assertions
bind mcl_modem_ctrl mcl_modem_ctrl_assertions #(.CLK_PER_MS(CLK_PER_MS), .SETTLE_MS(SETTLE_MS)) u_chk (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_rts_n(i_rts_n), .i_txd(i_txd), .i_status(i_status),
   .i_tx_space(i_tx_space), .i_ring_on(i_ring_on), .i_data_connected(i_data_connected),
   .o_cts_n(o_cts_n), .o_dsr_n(o_dsr_n), .o_ri_n(o_ri_n), .o_dcd_n(o_dcd_n),
   .o_link_status_lamp_n(o_link_status_lamp_n), .o_cmd_ready(o_cmd_ready), .o_txd(o_txd),
   .o_rx_deliver_ok(o_rx_deliver_ok), .o_offhook(o_offhook), .o_hangup(o_hangup), .o_cfg_reload(o_cfg_reload));
`default_nettype wire

/* File: verif/mcl_host_dte.sv */
// Host terminal model that drives the host pins of the modem control block.
// Assumes it shares i_clk and sees the block's pin outputs directly.
`timescale 1ns/10ps
`default_nettype none
module mcl_host_dte (
   // Clock, reset and bench commands.
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_dtr_off,
   input wire logic i_rx_stop,
   input wire logic i_tx_bit,
   // Pins seen from the module.
   input wire logic i_cts_n,
   input wire logic i_dsr_n,
   input wire logic i_dcd_n,
   // Pins driven towards the module; o_carrier goes to the bench.
   output logic o_rts_n,
   output logic o_dtr_n,
   output logic o_txd,
   output logic o_carrier
);
   // Pins change just after the edge; the data line idles at mark.
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_rts_n <= 1'b1;
         o_dtr_n <= 1'b0;
         o_txd <= 1'b1;
      end else begin
         o_rts_n <= i_rx_stop;
         o_dtr_n <= i_dtr_off;
         o_txd <= i_cts_n ? 1'b1 : i_tx_bit;
      end
   end
   // Carrier is only believed while data-set-ready is on.
   assign o_carrier = !i_dsr_n && !i_dcd_n;
endmodule : mcl_host_dte
`default_nettype wire

/* File: verif/modem_control_and_status_led_tb_top.sv */
// Self-checking bench for the modem control and lamp block.
// Assumes the bound checker and the host model beside the design.
`timescale 1ns/10ps
`default_nettype none
module modem_control_and_status_led_tb_top;
   localparam int CPM = 10; // Short millisecond keeps the run brief.
   localparam int XF = mcl_pkg::XFER_FLASH_MS * CPM; // Transfer flash length in cycles.
   logic clk = 1'b0, nrst = 1'b0, dtr_off = 1'b0, rx_stop = 1'b0, tx_bit = 1'b1, rts_n, dtr_n, txd, carrier;
   logic nv_valid = 1'b1, cfg_wr = 1'b0, tx_space = 1'b0, ring_on = 1'b0, answer_req = 1'b0, data_conn = 1'b0;
   mcl_pkg::mcl_cfg_t nv_cfg = 5'h0a, cfg_data = 5'h0, cfg;
   mcl_pkg::mcl_status_t status = 5'h0;
   logic cts_n, dsr_n, ri_n, dcd_n, lamp_n, ready, txd_out, deliver, offhook, keep, to_cmd, hangup, reload;
   int mismatches = 0, tests_run = 0, n;
   logic [15:0] seed = 16'h5c52; // Fixed seed keeps runs repeatable.
   logic [2:0] seen;
   always #50 clk = ~clk;
   mcl_modem_ctrl #(.CLK_PER_MS(CPM), .SETTLE_MS(2)) DUT (.i_clk(clk), .i_nrst(nrst), .i_rts_n(rts_n),
      .i_dtr_n(dtr_n), .i_txd(txd), .i_nv_valid(nv_valid), .i_nv_cfg(nv_cfg), .i_cfg_wr(cfg_wr),
      .i_cfg_data(cfg_data), .i_status(status), .i_tx_space(tx_space), .i_ring_on(ring_on),
      .i_answer_req(answer_req), .i_data_connected(data_conn), .o_cts_n(cts_n), .o_dsr_n(dsr_n),
      .o_ri_n(ri_n), .o_dcd_n(dcd_n), .o_link_status_lamp_n(lamp_n), .o_cmd_ready(ready), .o_txd(txd_out),
      .o_rx_deliver_ok(deliver), .o_offhook(offhook), .o_keep_connection(keep), .o_to_cmd_mode(to_cmd),
      .o_hangup(hangup), .o_cfg_reload(reload), .o_cfg(cfg));
   mcl_host_dte u_host (.i_clk(clk), .i_nrst(nrst), .i_dtr_off(dtr_off), .i_rx_stop(rx_stop),
      .i_tx_bit(tx_bit), .i_cts_n(cts_n), .i_dsr_n(dsr_n), .i_dcd_n(dcd_n), .o_rts_n(rts_n),
      .o_dtr_n(dtr_n), .o_txd(txd), .o_carrier(carrier));
   // Stop in the edge's own time step: inputs set now land by non-blocking assignment at this edge,
   // and outputs read now are the values that settled before it.
   task automatic tick(input int c);
      repeat (c) @(posedge clk);
   endtask : tick
   // Count and report one comparison.
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk
   task automatic final_report;
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : final_report
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // Expected {command mode, hangup, reload} pulses for a terminal-ready drop.
   function automatic logic [2:0] exp_pulse(input logic [1:0] b, input logic [2:0] a);
      if (a == mcl_pkg::ASYNC_DIRECT || b == mcl_pkg::DTRB_IGNORE)
         return 3'h0;
      return (b == mcl_pkg::DTRB_CMD) ? 3'h4 : ((b == mcl_pkg::DTRB_HANGUP) ? 3'h2 : 3'h3);
   endfunction : exp_pulse
   // Expected lamp run length in cycles; k counts runs after the first lit one.
   function automatic int exp_len(input bit ctx, input int k);
      if (!ctx)
         return mcl_pkg::REG_ON_MS * CPM;
      return (k == 2 ? mcl_pkg::CTX_GAP_MS : mcl_pkg::CTX_FLASH_MS) * CPM;
   endfunction : exp_len
   // Length of the next run of the lamp at level lvl, bounded against hangs.
   task automatic run_len(input logic lvl, output int r);
      int w;
      w = 0;
      r = 0;
      while (lamp_n !== lvl && w < 40000) begin
         tick(1);
         w++;
      end
      while (lamp_n === lvl && r < 40000) begin
         tick(1);
         r++;
      end
      if (w >= 40000 || r >= 40000) begin
         mismatches++;
         final_report();
      end
   endtask : run_len
   initial begin
      tick(5);
      chk("cfg in reset", {mcl_pkg::DFLT_DTRB, mcl_pkg::DFLT_ASYNC}, cfg);
      nrst <= 1'b1;
      tx_space <= 1'b1;
      tick(2);
      chk("cfg boot", nv_cfg, cfg);
      n = 2;
      while (ready !== 1'b1 && n < 100) begin
         tick(1);
         n++;
      end
      chk("settle", 1'b1, n >= CPM && n <= 3 * CPM);
      tick(2);
      chk("dsr", 1'b0, dsr_n);
      $display("test reset done");
      // Every behaviour code, then async mode 0 where the off edge causes no reaction.
      for (int i = 0; i < 5; i++) begin
         logic [1:0] b;
         logic [2:0] a;
         // The last pass pairs an acting code with the direct mode.
         b = (i == 4) ? mcl_pkg::DTRB_HANGUP : i[1:0];
         a = (i == 4) ? mcl_pkg::ASYNC_DIRECT : mcl_pkg::DFLT_ASYNC;
         cfg_data <= {b, a};
         cfg_wr <= 1'b1;
         tick(1);
         cfg_wr <= 1'b0;
         tick(6);
         chk("cfg write", {b, a}, cfg);
         chk("keep", 1'b1, keep);
         dtr_off <= 1'b1;
         seen = 3'h0;
         repeat (10) begin
            tick(1);
            seen = seen | {to_cmd, hangup, reload};
         end
         chk("dtr pulses", exp_pulse(b, a), seen);
         chk("keep off", 1'b0, keep);
         if (i == 3)
            chk("cfg reload", nv_cfg, cfg);
         dtr_off <= 1'b0;
      end
      $display("test terminal ready done");
      answer_req <= 1'b1;
      ring_on <= 1'b1;
      tick(3);
      chk("ri on", 2'h0, {ri_n, offhook});
      ring_on <= 1'b0;
      tick(3);
      chk("ri off", 2'h3, {ri_n, offhook});
      data_conn <= 1'b1;
      tick(3);
      chk("carrier", 1'b1, carrier);
      data_conn <= 1'b0;
      $display("test ring done");
      // Registration blink, then context double flash, each from dark.
      for (int m = 0; m < 2; m++) begin
         status <= 5'h0;
         tick(5);
         chk("dark", 1'b1, lamp_n);
         status <= (m == 0) ? 5'h11 : 5'h12;
         run_len(1'b0, n);
         for (int k = 0; k < 4; k++) begin
            run_len(k % 2 == 0, n);
            chk("lamp run", exp_len(m, k), n);
         end
      end
      status <= 5'h14;
      tick(1);
      // Engine on and nothing else, so the lamp goes dark when the flash ends.
      status <= 5'h10;
      tick(3);
      chk("xfer lit", 1'b0, lamp_n);
      run_len(1'b0, n);
      // The pin was already lit one cycle before the count started.
      n = n + 1;
      chk("xfer len", 1'b1, n >= XF - CPM && n <= XF + CPM);
      $display("test lamp done");
      // Random traffic on tx space, data connected, ring and status with the engine on, plus tx bit and rx stop; the bound checker judges it.
      repeat (3000) begin
         seed = lfsr(seed);
         {tx_space, data_conn, tx_bit, rx_stop, ring_on} <= seed[4:0];
         status <= {1'b1, seed[15:12]} & {1'b1, seed[11:8]};
         tick(1);
      end
      $display("test random done");
      final_report();
   end
endmodule : modem_control_and_status_led_tb_top
`default_nettype wire
